// File: common/gio_pkg.sv
package gio_pkg;

    // Register offsets on the 8-bit register port.
    localparam logic [7:0] ADR_PA_DATA      = 8'h00;
    localparam logic [7:0] ADR_PA_DIR       = 8'h01;
    localparam logic [7:0] ADR_PA_PU        = 8'h02;
    localparam logic [7:0] ADR_PA_WAKE      = 8'h03;
    localparam logic [7:0] ADR_PB_DATA      = 8'h04;
    localparam logic [7:0] ADR_PB_DIR       = 8'h05;
    localparam logic [7:0] ADR_PB_PU        = 8'h06;
    localparam logic [7:0] ADR_PC_DATA      = 8'h07;
    localparam logic [7:0] ADR_PC_DIR       = 8'h08;
    localparam logic [7:0] ADR_PC_PU        = 8'h09;
    localparam logic [7:0] ADR_PD_DATA      = 8'h0a;
    localparam logic [7:0] ADR_PD_DIR       = 8'h0b;
    localparam logic [7:0] ADR_PD_PU        = 8'h0c;
    localparam logic [7:0] ADR_ANALOG_SEL   = 8'h0d;
    localparam logic [7:0] ADR_PIN_FUNC     = 8'h0e;
    localparam logic [7:0] ADR_LCD_COM      = 8'h0f;
    localparam logic [7:0] ADR_WAKE_STATUS  = 8'h10;

    // Implemented-bit masks and reset values.
    localparam logic [7:0] MASK_PA_PU       = 8'h7f;
    localparam logic [1:0] MASK_PD          = 2'h3;
    localparam logic [7:0] RST_DATA         = 8'hff;
    localparam logic [7:0] RST_DIR          = 8'hff;
    localparam logic [7:0] RST_EN           = 8'h00;
    localparam logic [1:0] RST_PD_ONES      = 2'h3;
    localparam logic [1:0] RST_PD_ZERO      = 2'h0;
    localparam logic [7:0] RD_ZERO          = 8'h00;

    // Shared pin positions within their ports.
    localparam int BIT_INT   = 0;
    localparam int BIT_TMR0  = 1;
    localparam int BIT_TMR1  = 2;
    localparam int BIT_FDIV  = 3;
    localparam int BIT_PWM0  = 4;
    localparam int BIT_PWM1  = 5;
    localparam int BIT_COM_L = 6;
    localparam int BIT_COM_H = 7;

    // Pin function control fields.
    localparam int FN_FDIV_EN = 0;
    localparam int FN_PWM0_EN = 1;
    localparam int FN_PWM1_EN = 2;

    // LCD common driver control fields.
    localparam int LCD_EN     = 7;
    localparam int LCD_PB6    = 0;
    localparam int LCD_PB7    = 1;
    localparam int LCD_PC6    = 2;
    localparam int LCD_PC7    = 3;

    localparam int WAKE_FLAG_BIT = 0;

    typedef struct packed {
        logic [1:0] pd;
        logic [7:0] pc;
        logic [7:0] pb;
        logic [7:0] pa;
    } gio_pins_t;

    typedef struct packed {
        gio_pins_t  s1;
        gio_pins_t  s2;
        gio_pins_t  s3;
        gio_pins_t  pin;
        logic [7:0] pa_dat;
        logic [7:0] pa_dir;
        logic [7:0] pa_pu;
        logic [7:0] pa_wk;
        logic [7:0] pb_dat;
        logic [7:0] pb_dir;
        logic [7:0] pb_pu;
        logic [7:0] pc_dat;
        logic [7:0] pc_dir;
        logic [7:0] pc_pu;
        logic [1:0] pd_dat;
        logic [1:0] pd_dir;
        logic [1:0] pd_pu;
        logic [7:0] an_sel;
        logic [7:0] fn_ctl;
        logic [7:0] lcd_ctl;
        logic [7:0] rdata;
        logic       wake_flag;
        logic       wake_pls;
        gio_pins_t  oe;
        gio_pins_t  dout;
        gio_pins_t  pu;
        logic [3:0] bias;
        logic       int_pin;
        logic       tmr0_pin;
        logic       tmr1_pin;
    } gio_state_t;

endpackage

// File: hw/gio_port_block.sv
`timescale 1ns/1ps
//Function
//- Input pin reads sample the live pin level.
//- Output latch holds value until rewritten.
//- Input pull-up follows its enable bit.
//- Port A bit seven has no pull-up.
//- Sleep ends on enabled port A falling edge.
//- Each port A pin has wake enable.
//- Output pin reads return the latch.
//- Unimplemented bits read zero, ignore writes.
//- Reset: direction and latch ones, enables zero.
//- Interrupt pin keeps I/O, needs input direction.
//- Timer pins feed timers only as inputs.
//- Divider output drives only when pin outputs.
//- PWM drives only when pin is output.
//- Four pins make half-bias LCD commons.
//- Analog selection disconnects the pin pull-up.
//- Bit instructions write back the whole byte.
module gio_port_block (
    input  wire logic       CLK_IN,
    input  wire logic       SYS_RST_IN,
    input  wire logic [7:0] REG_ADDR_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    output logic      [7:0] REG_RDATA_OUT,
    input  wire logic [7:0] PA_IN,
    output logic      [7:0] PA_OUT,
    output logic      [7:0] PA_OE_OUT,
    output logic      [7:0] PA_PU_OUT,
    input  wire logic [7:0] PB_IN,
    output logic      [7:0] PB_OUT,
    output logic      [7:0] PB_OE_OUT,
    output logic      [7:0] PB_PU_OUT,
    input  wire logic [7:0] PC_IN,
    output logic      [7:0] PC_OUT,
    output logic      [7:0] PC_OE_OUT,
    output logic      [7:0] PC_PU_OUT,
    input  wire logic [1:0] PD_IN,
    output logic      [1:0] PD_OUT,
    output logic      [1:0] PD_OE_OUT,
    output logic      [1:0] PD_PU_OUT,
    output logic      [3:0] LCD_BIAS_OUT,
    input  wire logic       FDIV_IN,
    input  wire logic [1:0] PWM_IN,
    input  wire logic [1:0] TMR_EXT_MODE_IN,
    input  wire logic       HALT_IN,
    output logic            WAKE_OUT,
    output logic            INT_PIN_OUT,
    output logic            TMR0_PIN_OUT,
    output logic            TMR1_PIN_OUT
);

    gio_pkg::gio_state_t st_ff;
    gio_pkg::gio_state_t nxt_st;
    gio_pkg::gio_pins_t  raw_pins;
    gio_pkg::gio_pins_t  agree;
    logic          [7:0] pa_fall;
    logic          [7:0] wd;
    logic                wr;
    logic                com_pb6;
    logic                com_pb7;
    logic                com_pc6;
    logic                com_pc7;

    assign raw_pins = {PD_IN, PC_IN, PB_IN, PA_IN};

    always_comb begin
        nxt_st   = st_ff;
        wd       = REG_WDATA_IN;
        wr       = REG_WR_IN;

        // Three-stage synchroniser; a change counts once stages two and
        // three agree, so a single sampled glitch never reaches software.
        nxt_st.s1 = raw_pins;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        agree     = ~(st_ff.s2 ^ st_ff.s3);
        nxt_st.pin = (st_ff.s2 & agree) | (st_ff.pin & ~agree);

        // The falling-edge detector keeps running whatever the core does.
        pa_fall = st_ff.pin.pa & ~nxt_st.pin.pa & st_ff.pa_wk;
        nxt_st.wake_pls = HALT_IN && (pa_fall != 8'h00)
                          && !st_ff.wake_pls;

        // Register writes land on the next edge; a write carries the whole
        // byte, which is how bit set and clear instructions arrive.
        if (wr) begin
            unique case (REG_ADDR_IN)
                gio_pkg::ADR_PA_DATA:  nxt_st.pa_dat = wd;
                gio_pkg::ADR_PA_DIR:   nxt_st.pa_dir = wd;
                gio_pkg::ADR_PA_PU:
                    nxt_st.pa_pu  = wd & gio_pkg::MASK_PA_PU;
                gio_pkg::ADR_PA_WAKE:  nxt_st.pa_wk  = wd;
                gio_pkg::ADR_PB_DATA:  nxt_st.pb_dat = wd;
                gio_pkg::ADR_PB_DIR:   nxt_st.pb_dir = wd;
                gio_pkg::ADR_PB_PU:    nxt_st.pb_pu  = wd;
                gio_pkg::ADR_PC_DATA:  nxt_st.pc_dat = wd;
                gio_pkg::ADR_PC_DIR:   nxt_st.pc_dir = wd;
                gio_pkg::ADR_PC_PU:    nxt_st.pc_pu  = wd;
                gio_pkg::ADR_PD_DATA:
                    nxt_st.pd_dat = wd[1:0] & gio_pkg::MASK_PD;
                gio_pkg::ADR_PD_DIR:
                    nxt_st.pd_dir = wd[1:0] & gio_pkg::MASK_PD;
                gio_pkg::ADR_PD_PU:
                    nxt_st.pd_pu  = wd[1:0] & gio_pkg::MASK_PD;
                gio_pkg::ADR_ANALOG_SEL: nxt_st.an_sel = wd;
                gio_pkg::ADR_PIN_FUNC:   nxt_st.fn_ctl = wd;
                gio_pkg::ADR_LCD_COM:    nxt_st.lcd_ctl = wd;
                default: ;
            endcase
        end

        // Wake flag: write one to clear; a new event in the same cycle wins.
        if (wr && (REG_ADDR_IN == gio_pkg::ADR_WAKE_STATUS)
            && wd[gio_pkg::WAKE_FLAG_BIT]) begin
            nxt_st.wake_flag = 1'b0;
        end
        if (nxt_st.wake_pls) begin
            nxt_st.wake_flag = 1'b1;
        end

        // Reads return the filtered live pin for inputs and the latch for
        // outputs; nothing is captured ahead of the read itself.
        nxt_st.rdata = gio_pkg::RD_ZERO;
        if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                gio_pkg::ADR_PA_DATA: nxt_st.rdata =
                    (st_ff.pin.pa & st_ff.pa_dir)
                    | (st_ff.pa_dat & ~st_ff.pa_dir);
                gio_pkg::ADR_PA_DIR:  nxt_st.rdata = st_ff.pa_dir;
                gio_pkg::ADR_PA_PU:   nxt_st.rdata = st_ff.pa_pu;
                gio_pkg::ADR_PA_WAKE: nxt_st.rdata = st_ff.pa_wk;
                gio_pkg::ADR_PB_DATA: nxt_st.rdata =
                    (st_ff.pin.pb & st_ff.pb_dir)
                    | (st_ff.pb_dat & ~st_ff.pb_dir);
                gio_pkg::ADR_PB_DIR:  nxt_st.rdata = st_ff.pb_dir;
                gio_pkg::ADR_PB_PU:   nxt_st.rdata = st_ff.pb_pu;
                gio_pkg::ADR_PC_DATA: nxt_st.rdata =
                    (st_ff.pin.pc & st_ff.pc_dir)
                    | (st_ff.pc_dat & ~st_ff.pc_dir);
                gio_pkg::ADR_PC_DIR:  nxt_st.rdata = st_ff.pc_dir;
                gio_pkg::ADR_PC_PU:   nxt_st.rdata = st_ff.pc_pu;
                gio_pkg::ADR_PD_DATA: nxt_st.rdata = {6'h00,
                    (st_ff.pin.pd & st_ff.pd_dir)
                    | (st_ff.pd_dat & ~st_ff.pd_dir)};
                gio_pkg::ADR_PD_DIR:  nxt_st.rdata = {6'h00, st_ff.pd_dir};
                gio_pkg::ADR_PD_PU:   nxt_st.rdata = {6'h00, st_ff.pd_pu};
                gio_pkg::ADR_ANALOG_SEL:  nxt_st.rdata = st_ff.an_sel;
                gio_pkg::ADR_PIN_FUNC:    nxt_st.rdata = st_ff.fn_ctl;
                gio_pkg::ADR_LCD_COM:     nxt_st.rdata = st_ff.lcd_ctl;
                gio_pkg::ADR_WAKE_STATUS:
                    nxt_st.rdata = {7'h00, st_ff.wake_flag};
                default: nxt_st.rdata = gio_pkg::RD_ZERO;
            endcase
        end

        // Pin drive: direction zero drives the latch as CMOS output, except on port C pins with analog selection.
        nxt_st.oe.pa   = ~st_ff.pa_dir;
        nxt_st.oe.pb   = ~st_ff.pb_dir;
        nxt_st.oe.pc   = ~st_ff.pc_dir & ~st_ff.an_sel;
        nxt_st.oe.pd   = ~st_ff.pd_dir;
        nxt_st.dout.pa = st_ff.pa_dat;
        nxt_st.dout.pb = st_ff.pb_dat;
        nxt_st.dout.pc = st_ff.pc_dat;
        nxt_st.dout.pd = st_ff.pd_dat;

        // Alternate outputs replace the latch value whatever the direction, but only output
        // pins drive it; an input pin stays an ordinary input with its own pull-up choice.
        if (st_ff.fn_ctl[gio_pkg::FN_FDIV_EN]) begin
            nxt_st.dout.pa[gio_pkg::BIT_FDIV] = FDIV_IN;
        end
        if (st_ff.fn_ctl[gio_pkg::FN_PWM0_EN]) begin
            nxt_st.dout.pa[gio_pkg::BIT_PWM0] = PWM_IN[0];
        end
        if (st_ff.fn_ctl[gio_pkg::FN_PWM1_EN]) begin
            nxt_st.dout.pb[gio_pkg::BIT_PWM1] = PWM_IN[1];
        end

        // Pull-ups only on input pins; analog pins lose theirs.
        nxt_st.pu.pa = st_ff.pa_dir & st_ff.pa_pu
                       & gio_pkg::MASK_PA_PU;
        nxt_st.pu.pb = st_ff.pb_dir & st_ff.pb_pu;
        nxt_st.pu.pc = st_ff.pc_dir & st_ff.pc_pu
                       & ~st_ff.an_sel;
        nxt_st.pu.pd = st_ff.pd_dir & st_ff.pd_pu;

        // LCD commons take the pin over: no digital drive, no pull-up, and
        // the pad's half-bias network is switched on instead.
        com_pb6 = st_ff.lcd_ctl[gio_pkg::LCD_EN]
                  && st_ff.lcd_ctl[gio_pkg::LCD_PB6];
        com_pb7 = st_ff.lcd_ctl[gio_pkg::LCD_EN]
                  && st_ff.lcd_ctl[gio_pkg::LCD_PB7];
        com_pc6 = st_ff.lcd_ctl[gio_pkg::LCD_EN]
                  && st_ff.lcd_ctl[gio_pkg::LCD_PC6];
        com_pc7 = st_ff.lcd_ctl[gio_pkg::LCD_EN]
                  && st_ff.lcd_ctl[gio_pkg::LCD_PC7];
        nxt_st.bias = {com_pc7, com_pc6, com_pb7, com_pb6};
        if (com_pb6) begin
            nxt_st.oe.pb[gio_pkg::BIT_COM_L] = 1'b0;
            nxt_st.pu.pb[gio_pkg::BIT_COM_L] = 1'b0;
        end
        if (com_pb7) begin
            nxt_st.oe.pb[gio_pkg::BIT_COM_H] = 1'b0;
            nxt_st.pu.pb[gio_pkg::BIT_COM_H] = 1'b0;
        end
        if (com_pc6) begin
            nxt_st.oe.pc[gio_pkg::BIT_COM_L] = 1'b0;
            nxt_st.pu.pc[gio_pkg::BIT_COM_L] = 1'b0;
        end
        if (com_pc7) begin
            nxt_st.oe.pc[gio_pkg::BIT_COM_H] = 1'b0;
            nxt_st.pu.pc[gio_pkg::BIT_COM_H] = 1'b0;
        end

        // The interrupt and timer pins keep their I/O role; the timers see
        // them only while the pin is an input and in an external mode.
        nxt_st.int_pin = st_ff.pin.pa[gio_pkg::BIT_INT]
                         & st_ff.pa_dir[gio_pkg::BIT_INT];
        nxt_st.tmr0_pin = st_ff.pin.pa[gio_pkg::BIT_TMR0]
                          & st_ff.pa_dir[gio_pkg::BIT_TMR0]
                          & TMR_EXT_MODE_IN[0];
        nxt_st.tmr1_pin = st_ff.pin.pa[gio_pkg::BIT_TMR1]
                          & st_ff.pa_dir[gio_pkg::BIT_TMR1]
                          & TMR_EXT_MODE_IN[1];
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            st_ff           <= '0;
            st_ff.s1        <= '1;
            st_ff.s2        <= '1;
            st_ff.s3        <= '1;
            st_ff.pin       <= '1;
            st_ff.pa_dat    <= gio_pkg::RST_DATA;
            st_ff.pa_dir    <= gio_pkg::RST_DIR;
            st_ff.pa_pu     <= gio_pkg::RST_EN;
            st_ff.pa_wk     <= gio_pkg::RST_EN;
            st_ff.pb_dat    <= gio_pkg::RST_DATA;
            st_ff.pb_dir    <= gio_pkg::RST_DIR;
            st_ff.pb_pu     <= gio_pkg::RST_EN;
            st_ff.pc_dat    <= gio_pkg::RST_DATA;
            st_ff.pc_dir    <= gio_pkg::RST_DIR;
            st_ff.pc_pu     <= gio_pkg::RST_EN;
            st_ff.pd_dat    <= gio_pkg::RST_PD_ONES;
            st_ff.pd_dir    <= gio_pkg::RST_PD_ONES;
            st_ff.pd_pu     <= gio_pkg::RST_PD_ZERO;
            st_ff.dout      <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign REG_RDATA_OUT = st_ff.rdata;
    assign PA_OUT        = st_ff.dout.pa;
    assign PA_OE_OUT     = st_ff.oe.pa;
    assign PA_PU_OUT     = st_ff.pu.pa;
    assign PB_OUT        = st_ff.dout.pb;
    assign PB_OE_OUT     = st_ff.oe.pb;
    assign PB_PU_OUT     = st_ff.pu.pb;
    assign PC_OUT        = st_ff.dout.pc;
    assign PC_OE_OUT     = st_ff.oe.pc;
    assign PC_PU_OUT     = st_ff.pu.pc;
    assign PD_OUT        = st_ff.dout.pd;
    assign PD_OE_OUT     = st_ff.oe.pd;
    assign PD_PU_OUT     = st_ff.pu.pd;
    assign LCD_BIAS_OUT  = st_ff.bias;
    assign WAKE_OUT      = st_ff.wake_pls;
    assign INT_PIN_OUT   = st_ff.int_pin;
    assign TMR0_PIN_OUT  = st_ff.tmr0_pin;
    assign TMR1_PIN_OUT  = st_ff.tmr1_pin;

endmodule // gio_port_block

// File: testbench/gio_pin_model.sv
`timescale 1ns/1ps
module gio_pin_model #(
    parameter int W = 8
) (
    input  wire logic         clk_in,
    input  wire logic [W-1:0] out_in,
    input  wire logic [W-1:0] oe_in,
    input  wire logic [W-1:0] pu_in,
    input  wire logic [W-1:0] ext_in,
    input  wire logic [W-1:0] ext_en_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] float_ff = '0;

    always_ff @(posedge clk_in) begin
        float_ff <= ~float_ff;
    end

    // A pin nobody holds toggles every clock, so the filter never accepts it and reads keep the last settled level.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_in[i]) begin
                pin_out[i] = out_in[i];
            end else if (ext_en_in[i]) begin
                pin_out[i] = ext_in[i];
            end else if (pu_in[i]) begin
                pin_out[i] = 1'b1;
            end else begin
                pin_out[i] = float_ff[i];
            end
        end
    end
endmodule // gio_pin_model

// File: testbench/gio_port_block_properties.sv
`timescale 1ns/1ps
module gio_port_block_properties (
    input wire logic       CLK_IN,
    input wire logic       SYS_RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic       REG_WR_IN,
    input wire logic       REG_RD_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic [7:0] PA_OUT,
    input wire logic [7:0] PA_OE_OUT,
    input wire logic [7:0] PA_PU_OUT,
    input wire logic [7:0] PB_OE_OUT,
    input wire logic [7:0] PB_PU_OUT,
    input wire logic [7:0] PC_PU_OUT,
    input wire logic [3:0] LCD_BIAS_OUT,
    input wire logic       HALT_IN,
    input wire logic       WAKE_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    a_rdata_idle: assert property (!$past(REG_RD_IN) |->
        REG_RDATA_OUT == 8'h00) else $error("read data outside its slot");
    a_pa7_nopull: assert property (PA_PU_OUT[7] == 1'b0)
        else $error("port A bit seven pulled up");
    a_pull_input: assert property (((PA_PU_OUT & PA_OE_OUT) |
        (PB_PU_OUT & PB_OE_OUT)) == 8'h00) else $error("pull-up on output");
    a_lcd_release: assert property (LCD_BIAS_OUT[1:0] != 2'h0 |->
        ({PB_OE_OUT[7:6], PB_PU_OUT[7:6]} & {2{LCD_BIAS_OUT[1:0]}}) == 4'h0)
        else $error("common pin still driven");
    a_wake_halt: assert property (WAKE_OUT |-> $past(HALT_IN))
        else $error("wake while awake");
    a_wake_pulse: assert property (WAKE_OUT |=> !WAKE_OUT)
        else $error("wake pulse too long");
    a_dir_oe: assert property ((REG_WR_IN &&
        REG_ADDR_IN == gio_pkg::ADR_PA_DIR) |-> ##2
        PA_OE_OUT == ~$past(REG_WDATA_IN, 2)) else $error("direction lost");
    a_latch_out: assert property ((REG_WR_IN &&
        REG_ADDR_IN == gio_pkg::ADR_PA_DATA) |-> ##2 ((PA_OUT ^
        $past(REG_WDATA_IN, 2)) & PA_OE_OUT & 8'he7) == 8'h00)
        else $error("latch not on pins");
    a_pu_follow: assert property ((REG_WR_IN &&
        REG_ADDR_IN == gio_pkg::ADR_PA_PU) |-> ##2 PA_PU_OUT ==
        ($past(REG_WDATA_IN, 2) & gio_pkg::MASK_PA_PU & ~PA_OE_OUT))
        else $error("pull-up enable lost");
    a_analog_pu: assert property ((REG_WR_IN &&
        REG_ADDR_IN == gio_pkg::ADR_ANALOG_SEL) |-> ##2
        (PC_PU_OUT & $past(REG_WDATA_IN, 2)) == 8'h00)
        else $error("analog pin pulled up");
endmodule // gio_port_block_properties

bind gio_port_block gio_port_block_properties chk_u (.*);

// File: testbench/gio_port_block_test.sv
`timescale 1ns/1ps
module gio_port_block_test;
    logic       CLK_IN, SYS_RST_IN, REG_WR_IN, REG_RD_IN, HALT_IN, FDIV_IN;
    logic       WAKE_OUT, INT_PIN_OUT, TMR0_PIN_OUT, TMR1_PIN_OUT;
    logic [1:0] PWM_IN, TMR_EXT_MODE_IN, PD_IN, PD_OUT, PD_OE_OUT, PD_PU_OUT;
    logic [1:0] pd_x, pd_xe;
    logic [7:0] pb_x, pb_xe, pc_x, pc_xe;
    logic [3:0] LCD_BIAS_OUT;
    logic [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT, pa_x, pa_xe;
    logic [7:0] PA_IN, PA_OUT, PA_OE_OUT, PA_PU_OUT, PB_IN, PB_OUT, PB_OE_OUT;
    logic [7:0] PB_PU_OUT, PC_IN, PC_OUT, PC_OE_OUT, PC_PU_OUT;
    int         n_mismatch = 0;
    int         compares = 0;
    localparam logic [7:0] RA [9] = '{gio_pkg::ADR_PA_DIR, gio_pkg::ADR_PA_PU,
        gio_pkg::ADR_PA_WAKE, gio_pkg::ADR_PB_DIR, gio_pkg::ADR_PB_PU,
        gio_pkg::ADR_PC_DIR, gio_pkg::ADR_PC_PU, gio_pkg::ADR_PD_DIR,
        gio_pkg::ADR_PD_PU};
    localparam logic [7:0] RV [9] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'h00,
        8'hff, 8'h00, 8'h03, 8'h00};
    localparam logic [7:0] RM [9] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h03, 8'h03};

    gio_port_block dut_u (.*);
    gio_pin_model #(.W(8)) pa_u (.clk_in(CLK_IN), .out_in(PA_OUT),
        .oe_in(PA_OE_OUT), .pu_in(PA_PU_OUT), .ext_in(pa_x),
        .ext_en_in(pa_xe), .pin_out(PA_IN));
    gio_pin_model #(.W(8)) pb_u (.clk_in(CLK_IN), .out_in(PB_OUT),
        .oe_in(PB_OE_OUT), .pu_in(PB_PU_OUT), .ext_in(pb_x),
        .ext_en_in(pb_xe), .pin_out(PB_IN));
    gio_pin_model #(.W(8)) pc_u (.clk_in(CLK_IN), .out_in(PC_OUT),
        .oe_in(PC_OE_OUT), .pu_in(PC_PU_OUT), .ext_in(pc_x),
        .ext_en_in(pc_xe), .pin_out(PC_IN));
    gio_pin_model #(.W(2)) pd_u (.clk_in(CLK_IN), .out_in(PD_OUT),
        .oe_in(PD_OE_OUT), .pu_in(PD_PU_OUT), .ext_in(pd_x),
        .ext_en_in(pd_xe), .pin_out(PD_IN));

    initial begin
        CLK_IN = 1'b0;
        forever #20 CLK_IN = ~CLK_IN;
    end

    task automatic end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        REG_ADDR_IN  <= a;
        REG_WDATA_IN <= d;
        REG_WR_IN    <= 1'b1;
        @(posedge CLK_IN);
        REG_WR_IN    <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK_IN);
        REG_ADDR_IN <= a;
        REG_RD_IN   <= 1'b1;
        @(posedge CLK_IN);
        REG_RD_IN   <= 1'b0;
        @(negedge CLK_IN);
        chk(REG_RDATA_OUT, e);
    endtask

    // Pins pass a three-stage filter, so six edges cover every path.
    // It ends on a falling edge so the last update has surely landed.
    task automatic settle;
        repeat (6) @(posedge CLK_IN);
        @(negedge CLK_IN);
    endtask

    task automatic wwake(input logic e);
        logic s;
        s = 1'b0;
        repeat (10) begin
            @(negedge CLK_IN);
            s = s | WAKE_OUT;
        end
        chk(s, e);
    endtask

    initial begin
        SYS_RST_IN = 1'b1;
        {REG_WR_IN, REG_RD_IN, HALT_IN, FDIV_IN, PWM_IN, TMR_EXT_MODE_IN} = '0;
        {REG_ADDR_IN, REG_WDATA_IN, pa_x, pa_xe, pd_x, pd_xe} = '0;
        {pb_x, pb_xe, pc_x, pc_xe} = '0;
        repeat (16) @(posedge CLK_IN);
        SYS_RST_IN <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rc(RA[i], RV[i]);
        end
        chk(PA_OE_OUT, 8'h00);
        chk(PC_OUT, 8'hff);
        wr(gio_pkg::ADR_PD_DIR, 8'h00);
        settle;
        chk(PD_OUT, 2'h3);
        for (int i = 0; i < 9; i++) begin
            wr(RA[i], 8'hff);
            rc(RA[i], RM[i]);
        end
        wr(8'h20, 8'h5a);
        rc(8'h20, 8'h00);
        pa_xe <= 8'hff;
        pa_x <= 8'h5a;
        {pb_xe, pc_xe, pd_xe} <= {8'hff, 8'hff, 2'h3};
        {pb_x, pc_x, pd_x} <= {8'h96, 8'h69, 2'h2};
        settle;
        rc(gio_pkg::ADR_PA_DATA, 8'h5a);
        rc(gio_pkg::ADR_PB_DATA, 8'h96);
        rc(gio_pkg::ADR_PC_DATA, 8'h69);
        rc(gio_pkg::ADR_PD_DATA, 8'h02);
        pa_x <= 8'ha5;
        settle;
        rc(gio_pkg::ADR_PA_DATA, 8'ha5);
        wr(gio_pkg::ADR_PA_DATA, 8'h3c);
        wr(gio_pkg::ADR_PA_DIR, 8'h0f);
        settle;
        rc(gio_pkg::ADR_PA_DATA, 8'h35);
        chk(PA_PU_OUT, 8'h0f);
        pa_x <= 8'h00;
        settle;
        chk(PA_OUT & 8'hf0, 8'h30);
        wr(gio_pkg::ADR_PIN_FUNC, 8'h07);
        wr(gio_pkg::ADR_PB_DIR, 8'hdf);
        settle;
        chk({PA_OE_OUT[3], PA_OUT[4], PB_OUT[5]}, 8'h00);
        wr(gio_pkg::ADR_PA_DIR, 8'h00);
        FDIV_IN <= 1'b1;
        PWM_IN <= 2'h3;
        settle;
        chk({PA_OUT[4:3], PB_OUT[5]}, 8'h07);
        @(posedge CLK_IN);
        FDIV_IN <= 1'b0;
        settle;
        chk(PA_OUT[3], 8'h00);
        wr(gio_pkg::ADR_LCD_COM, 8'h8f);
        wr(gio_pkg::ADR_ANALOG_SEL, 8'h0f);
        settle;
        chk(LCD_BIAS_OUT, 8'h0f);
        chk(PC_PU_OUT, 8'h30);
        chk(PB_PU_OUT, 8'h1f);
        chk(PB_OE_OUT, 8'h20);
        chk({PD_OE_OUT, PD_PU_OUT}, 8'h03);
        wr(gio_pkg::ADR_PC_DIR, 8'h00);
        settle;
        chk(PC_OE_OUT, 8'h30);
        wr(gio_pkg::ADR_PA_DIR, 8'hff);
        pa_x <= 8'h07;
        TMR_EXT_MODE_IN <= 2'h1;
        settle;
        chk({INT_PIN_OUT, TMR0_PIN_OUT, TMR1_PIN_OUT}, 8'h06);
        wr(gio_pkg::ADR_PA_DIR, 8'hfe);
        TMR_EXT_MODE_IN <= 2'h2;
        settle;
        chk({INT_PIN_OUT, TMR0_PIN_OUT, TMR1_PIN_OUT}, 8'h01);
        wr(gio_pkg::ADR_PA_WAKE, 8'h04);
        pa_x <= 8'hff;
        HALT_IN <= 1'b1;
        settle;
        wr(gio_pkg::ADR_WAKE_STATUS, 8'h01);
        pa_x <= 8'hfd;
        wwake(1'b0);
        pa_x <= 8'hf9;
        wwake(1'b1);
        rc(gio_pkg::ADR_WAKE_STATUS, 8'h01);
        wr(gio_pkg::ADR_WAKE_STATUS, 8'h01);
        rc(gio_pkg::ADR_WAKE_STATUS, 8'h00);
        @(posedge CLK_IN);
        HALT_IN <= 1'b0;
        end_sim;
    end

    // The tests take well under a thousand cycles; this allows ten.
    initial begin
        #400000;
        n_mismatch++;
        end_sim;
    end
endmodule // gio_port_block_test
